// *** vpi_arbiter.sv ***
// Picks the valid entry with the highest level; ties go to the lowest index.
// Assumes entry index equals vector number.
`default_nettype none
module vpi_arbiter
  import vpi_pkg::*;
#(
  parameter int N = 24
) (
  // Candidates
  input wire logic [N-1:0] valid_i,
  input wire vpi_pkg::vpi_level_t level_i [N],
  // Winner
  output logic any_o,
  output vpi_pkg::vpi_vec_t index_o,
  output vpi_pkg::vpi_level_t level_o
);
  always_comb
  begin
    any_o = 1'b0;
    index_o = '0;
    level_o = '0;
    // Downward scan with >= lets the lower vector win a tie
    for (int i = N - 1; i >= 0; i--)
    begin
      if (valid_i[i] && (!any_o || level_i[i] >= level_o)) // R16
      begin
        any_o = 1'b1;
        index_o = 8'(i);
        level_o = level_i[i];
      end
    end
  end
endmodule // vpi_arbiter
`default_nettype wire

// *** vpi_core_model.sv ***
// Behavioural core: accepts the pending interrupt a set latency after it shows.
// Assumes it shares one clock and reset with the controller.
`default_nettype none
module vpi_core_model #(
  parameter int LAT = 2
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Controller side
  input wire logic irq_i,
  input wire logic en_i,
  output logic ack_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // One accept per request, only while the request line is high
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt <= 0;
      ack_o <= 1'b0;
    end
    else
    begin
      cnt <= (irq_i && en_i) ? cnt + 1 : 0;
      ack_o <= irq_i && en_i && cnt == LAT;
    end
  end
endmodule // vpi_core_model
`default_nettype wire

// *** vpi_ctrl.sv ***
// Vectored priority interrupt and trap controller with an APB register slave.
// Assumes peripheral requests arrive asynchronously; trap, ack and return come from the core clock.
`include "vpi_regs.svh"
`default_nettype none
module vpi_ctrl (
  // Clock and reset
  input wire logic REF_CLK_I,
  input wire logic RESET_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic PREADY_O,
  output logic PSLVERR_O,
  output logic [31:0] PRDATA_O,
  // Interrupt sources and trap events
  input wire logic [`VPI_NUM_SRC-1:0] SRC_REQ_I,
  input wire logic [`VPI_NUM_TRAPIN-1:0] TRAP_I,
  // Core side
  input wire logic ACK_I,
  input wire logic RETURN_I,
  output logic IRQ_O,
  output vpi_pkg::vpi_vec_t VECTOR_O,
  output vpi_pkg::vpi_level_t LEVEL_O,
  output vpi_pkg::vpi_level_t CPU_LEVEL_O
);
  import vpi_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [`VPI_NUM_SRC-1:0] flag;
  logic [`VPI_NUM_SRC-1:0] src_en;
  vpi_prio_t prio [`VPI_NUM_SRC];
  logic [`VPI_NUM_TRAPIN-1:0] trap_flag;
  logic nest_dis;
  logic global_irq_enable;
  logic [`VPI_NUM_EXT-1:0] ext_falling;
  logic [2:0] cpu_lo;
  logic cpu_top;
  logic pend_valid;
  vpi_vec_t pend_vec;
  vpi_level_t pend_lvl;
  logic [`VPI_NUM_SRC-1:0] src_sync;
  logic [`VPI_NUM_EXT-1:0] ext_prev;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  wire acc = PSEL_I && PENABLE_I;
  wire wr = acc && PWRITE_I;
  wire sel_flag = PADDR_I == `VPI_OFS_FLAG;
  wire sel_en = PADDR_I == `VPI_OFS_ENABLE;
  wire sel_prio = PADDR_I >= `VPI_OFS_PRIO_BASE && PADDR_I < `VPI_OFS_TRAPCTL && PADDR_I[1:0] == 2'b00;
  wire [1:0] prio_word = 2'(PADDR_I[5:2] - 4'h2);
  wire sel_trapctl = PADDR_I == `VPI_OFS_TRAPCTL;
  wire sel_extctl = PADDR_I == `VPI_OFS_EXTCTL;
  wire sel_dmaloop = PADDR_I == `VPI_OFS_DMALOOP;
  wire sel_softhard = PADDR_I == `VPI_OFS_SOFTHARD;
  wire sel_pending = PADDR_I == `VPI_OFS_PENDING;
  wire sel_cpustat = PADDR_I == `VPI_OFS_CPUSTAT;
  wire sel_corectl = PADDR_I == `VPI_OFS_CORECTL;
  wire mapped = sel_flag || sel_en || sel_prio || sel_trapctl || sel_extctl || sel_dmaloop
                || sel_softhard || sel_pending || sel_cpustat || sel_corectl;
  wire wr_flag = wr && sel_flag;
  wire wr_en = wr && sel_en;
  wire wr_prio = wr && sel_prio;
  wire wr_trapctl = wr && sel_trapctl;
  wire wr_extctl = wr && sel_extctl;
  wire wr_dmaloop = wr && sel_dmaloop;
  wire wr_softhard = wr && sel_softhard;
  wire wr_cpustat = wr && sel_cpustat;
  wire wr_corectl = wr && sel_corectl;

  assign PREADY_O = 1'b1;
  assign PSLVERR_O = acc && !mapped;

  ////////////////////////////////////////////////////////////////////////////
  // Source requests
  vpi_sync #(
    .WIDTH(`VPI_NUM_SRC)
  ) u_src_sync (
    .REF_CLK_I(REF_CLK_I),
    .RESET_I(RESET_I),
    .async_i(SRC_REQ_I),
    .sync_o(src_sync)
  );
  logic [`VPI_NUM_SRC-1:0] src_set;
  logic [`VPI_NUM_SRC-1:0] flag_clr;
  logic [31:0] prio_rd [4];
  genvar s;
  generate
    for (s = 0; s < `VPI_NUM_SRC; s++)
    begin : g_src
      if (s < `VPI_NUM_EXT)
      begin : g_ext
        // External lines flag on the selected edge
        assign src_set[s] = ext_falling[s] ? (ext_prev[s] && !src_sync[s])
                                           : (!ext_prev[s] && src_sync[s]); // R11
      end
      else
      begin : g_lvl
        assign src_set[s] = src_sync[s];
      end
      assign flag_clr[s] = wr_flag && PWDATA_I[s];
      // Priority slot s%4 of word s/4, bits 2:0 for the first source
      always_ff @(posedge REF_CLK_I or posedge RESET_I)
      begin
        if (RESET_I)
          prio[s] <= '0;
        else if (wr_prio && prio_word == 2'(s / 4))
          prio[s] <= PWDATA_I[4 * (s % 4) +: 3]; // R3 R9
      end
    end
    for (s = 0; s < 4; s++)
    begin : g_prio_rd
      assign prio_rd[s] = {17'h0, prio[4 * s + 3], 1'b0, prio[4 * s + 2], 1'b0,
                           prio[4 * s + 1], 1'b0, prio[4 * s]};
    end
  endgenerate

  always_ff @(posedge REF_CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      flag <= '0;
      src_en <= '0;
      ext_prev <= '0;
    end
    else
    begin
      // Set wins over a same-cycle clear
      flag <= (flag & ~flag_clr) | src_set; // R1 R9
      ext_prev <= src_sync[`VPI_NUM_EXT-1:0];
      if (wr_en)
        src_en <= PWDATA_I[`VPI_NUM_SRC-1:0]; // R2
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trap flags: 0 osc, 1 addr, 2 stack, 3 math, 4 dma_controller, 5 dma addr, 6 loop, 7 sw hard
  wire [`VPI_NUM_TRAPIN-1:0] trap_clr = {
    wr_softhard && PWDATA_I[`VPI_BIT_SWHARD], // R13
    wr_dmaloop && PWDATA_I[`VPI_BIT_LOOPOVF], // R12
    wr_dmaloop && PWDATA_I[`VPI_BIT_DMAADDR],
    wr_trapctl && PWDATA_I[`VPI_BIT_DMA_CONTROLLER], // R10
    wr_trapctl && PWDATA_I[`VPI_BIT_MATH],
    wr_trapctl && PWDATA_I[`VPI_BIT_STACK],
    wr_trapctl && PWDATA_I[`VPI_BIT_ADDR],
    wr_trapctl && PWDATA_I[`VPI_BIT_OSC]
  };

  always_ff @(posedge REF_CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      trap_flag <= '0;
      nest_dis <= 1'b0;
      global_irq_enable <= 1'(`VPI_RST_EXTCTL >> `VPI_BIT_GIE);
      ext_falling <= '0;
    end
    else
    begin
      trap_flag <= (trap_flag & ~trap_clr) | TRAP_I;
      if (wr_trapctl)
        nest_dis <= PWDATA_I[`VPI_BIT_NESTDIS]; // R10
      if (wr_extctl)
      begin
        global_irq_enable <= PWDATA_I[`VPI_BIT_GIE]; // R11
        ext_falling <= PWDATA_I[`VPI_NUM_EXT-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Candidates: index is the vector number
  wire vpi_level_t cpu_level = {cpu_top, cpu_lo};
  wire [6:0] trap_req = {
    trap_flag[5] || trap_flag[6], // Generic soft error
    trap_flag[4],                 // DMA controller error
    trap_flag[3],                 // Math error
    trap_flag[2],                 // Stack error
    trap_flag[7],                 // Generic hard trap
    trap_flag[1],                 // Address error
    trap_flag[0]                  // Oscillator failure
  }; // R7
  logic [`VPI_NUM_ENTRY-1:0] cand_valid;
  vpi_level_t cand_level [`VPI_NUM_ENTRY];
  logic cand_any;
  vpi_vec_t cand_vec;
  vpi_level_t cand_lvl;
  genvar e;
  generate
    for (e = 0; e < `VPI_NUM_ENTRY; e++)
    begin : g_cand
      if (e < 7)
      begin : g_trap
        // Traps ignore global enable and cpu level
        assign cand_valid[e] = trap_req[e]; // R17
        assign cand_level[e] = 4'(`VPI_TRAP_TOP_LEVEL - e);
      end
      else if (e == 7)
      begin : g_rsvd
        assign cand_valid[e] = 1'b0; // R7
        assign cand_level[e] = '0;
      end
      else
      begin : g_user
        assign cand_level[e] = {1'b0, prio[e - `VPI_USER_BASE]};
        assign cand_valid[e] = global_irq_enable && flag[e - `VPI_USER_BASE] && src_en[e - `VPI_USER_BASE]
                               && cand_level[e] > cpu_level; // R2 R16 R17 R8
      end
    end
  endgenerate

  vpi_arbiter #(
    .N(`VPI_NUM_ENTRY)
  ) u_arbiter (
    .valid_i(cand_valid),
    .level_i(cand_level),
    .any_o(cand_any),
    .index_o(cand_vec),
    .level_o(cand_lvl)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pending vector latch and cpu level
  wire pend_is_trap = pend_vec < vpi_vec_t'(`VPI_USER_BASE);
  wire take = ACK_I && pend_valid;
  always_ff @(posedge REF_CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      pend_valid <= 1'b0;
      pend_vec <= '0;
      pend_lvl <= '0;
    end
    else
    begin
      pend_valid <= cand_any;
      if (cand_any)
      begin
        pend_vec <= cand_vec; // R4
        pend_lvl <= cand_lvl; // R4 R6
      end
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      cpu_lo <= '0;
      cpu_top <= 1'b0;
    end
    else if (take)
    begin
      // Nesting disabled: user handlers run at the top user level
      cpu_lo <= (nest_dis && !pend_is_trap) ? 3'h7 : pend_lvl[2:0];
      cpu_top <= pend_lvl[3];
    end
    else
    begin
      if (wr_cpustat)
        cpu_lo <= PWDATA_I[`VPI_BIT_CPU_LO +: 3]; // R14
      if (RETURN_I)
        cpu_top <= 1'b0; // R15
    end
  end

  assign IRQ_O = pend_valid;
  assign VECTOR_O = pend_vec;
  assign LEVEL_O = pend_lvl;
  assign CPU_LEVEL_O = cpu_level;

  ////////////////////////////////////////////////////////////////////////////
  // Read mux
  wire [31:0] rd_trapctl = (32'(nest_dis) << `VPI_BIT_NESTDIS) | (32'(trap_flag[0]) << `VPI_BIT_OSC)
                         | (32'(trap_flag[1]) << `VPI_BIT_ADDR) | (32'(trap_flag[2]) << `VPI_BIT_STACK)
                         | (32'(trap_flag[3]) << `VPI_BIT_MATH) | (32'(trap_flag[4]) << `VPI_BIT_DMA_CONTROLLER);
  wire [31:0] rd_extctl = (32'(global_irq_enable) << `VPI_BIT_GIE) | 32'(ext_falling);
  wire [31:0] rd_dmaloop = (32'(trap_flag[5]) << `VPI_BIT_DMAADDR) | (32'(trap_flag[6]) << `VPI_BIT_LOOPOVF);
  wire [31:0] rd_softhard = 32'(trap_flag[7]) << `VPI_BIT_SWHARD;
  wire [31:0] rd_pending = {16'h0, 4'h0, pend_lvl, pend_vec}; // R5
  wire [31:0] rd_cpustat = 32'(cpu_lo) << `VPI_BIT_CPU_LO;
  wire [31:0] rd_corectl = 32'(cpu_top) << `VPI_BIT_CPU_TOP; // R15

  always_comb
  begin
    PRDATA_O = `VPI_RST_WORD;
    if (acc && !PWRITE_I)
    begin
      if (sel_flag)
        PRDATA_O = 32'(flag);
      else if (sel_en)
        PRDATA_O = 32'(src_en);
      else if (sel_prio)
        PRDATA_O = prio_rd[prio_word];
      else if (sel_trapctl)
        PRDATA_O = rd_trapctl;
      else if (sel_extctl)
        PRDATA_O = rd_extctl;
      else if (sel_dmaloop)
        PRDATA_O = rd_dmaloop;
      else if (sel_softhard)
        PRDATA_O = rd_softhard;
      else if (sel_pending)
        PRDATA_O = rd_pending;
      else if (sel_cpustat)
        PRDATA_O = rd_cpustat;
      else if (sel_corectl)
        PRDATA_O = rd_corectl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RESET_I);

  wire [3:0] cand_src = 4'(cand_vec - 8'h08);
  wire cand_user = cand_any && cand_vec >= vpi_vec_t'(`VPI_USER_BASE);
  wire user_pend = pend_valid && !pend_is_trap;
  property p_flag_sticky;
    |(flag & ~flag_clr) |=> (flag & $past(flag & ~flag_clr)) == $past(flag & ~flag_clr);
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped without clear"); // R1
  property p_enable_gates;
    cand_user |=> user_pend && $past(src_en[cand_src] && flag[cand_src]);
  endproperty
  a_enable_gates: assert property (p_enable_gates) else $error("disabled source presented"); // R2
  property p_user_level;
    cand_user |=> pend_lvl == {1'b0, $past(prio[cand_src])} && pend_lvl > $past(cpu_level);
  endproperty
  a_user_level: assert property (p_user_level) else $error("user level wrong"); // R16
  property p_trap_level;
    pend_valid && pend_is_trap |-> pend_lvl == 4'(`VPI_TRAP_TOP_LEVEL - pend_vec[3:0]);
  endproperty
  a_trap_level: assert property (p_trap_level) else $error("trap level wrong"); // R6
  property p_no_reserved;
    pend_valid |-> pend_vec != 8'h07 && pend_vec != 8'hFF;
  endproperty
  a_no_reserved: assert property (p_no_reserved) else $error("reserved vector presented"); // R8
  property p_pending_ro;
    acc && !PWRITE_I && sel_pending |-> PRDATA_O[31:12] == 20'h0 && PRDATA_O[11:0] == {pend_lvl, pend_vec};
  endproperty
  a_pending_ro: assert property (p_pending_ro) else $error("pending read wrong"); // R5
  property p_gie_users;
    !global_irq_enable |=> !user_pend;
  endproperty
  a_gie_users: assert property (p_gie_users) else $error("user shown with global enable off"); // R17
  property p_trap_shown;
    |trap_req |=> pend_valid && pend_is_trap;
  endproperty
  a_trap_shown: assert property (p_trap_shown) else $error("trap not presented"); // R17
  property p_top_ro;
    wr_corectl && !take && !RETURN_I |=> $stable(cpu_top);
  endproperty
  a_top_ro: assert property (p_top_ro) else $error("top level bit written by software"); // R15
  property p_cpu_write;
    wr_cpustat && !take |=> cpu_lo == $past(PWDATA_I[7:5]);
  endproperty
  a_cpu_write: assert property (p_cpu_write) else $error("cpu level write lost"); // R14
  c_user_irq: cover property (user_pend ##1 take);
  c_trap_irq: cover property (pend_valid && pend_is_trap);
  c_preempt: cover property (user_pend ##1 pend_valid && pend_is_trap);
endmodule // vpi_ctrl
`default_nettype wire

// *** vpi_pkg.sv ***
// Types shared by the interrupt controller modules.
// Assumes nothing beyond the constants header.
`default_nettype none
package vpi_pkg;
  typedef logic [3:0] vpi_level_t;
  typedef logic [7:0] vpi_vec_t;
  typedef logic [2:0] vpi_prio_t;
endpackage
`default_nettype wire

// *** vpi_regs.svh ***
// Register offsets, field positions, reset values and sizes of the vectored interrupt controller.
// Assumes byte addresses on a 32-bit APB bus, one register per aligned word.
//
// How it works
// R1: each source flag set by hardware, software-cleared
// R2: per-source enable gates the request
// R3: three-bit priority per user source, eight levels
// R4: pending vector and its level latched
// R5: pending register read-only, 16 bits, top zero
// R6: new level encoded plainly from 0 to 15
// R7: trap vectors 0 to 6 fixed, 7 reserved
// R8: user vectors start at 8, 255 never made
// R9: flag, enable, priority placed in vector order
// R10: first control: nesting disable and trap flags
// R11: second control: external edges, global enable
// R12: third control: DMA and loop-stack trap flags
// R13: fourth control: software hard trap flag
// R14: cpu level low bits writable at 7:5
// R15: cpu level top bit read-only to software
// R16: highest priority above cpu level, lowest vector
// R17: global enable gates users, never traps
`ifndef VPI_REGS_SVH
`define VPI_REGS_SVH

`define VPI_NUM_SRC 16
`define VPI_NUM_EXT 3
`define VPI_NUM_TRAPIN 8
`define VPI_NUM_ENTRY 24
`define VPI_USER_BASE 8
`define VPI_TRAP_TOP_LEVEL 4'hF

`define VPI_OFS_FLAG 12'h000
`define VPI_OFS_ENABLE 12'h004
`define VPI_OFS_PRIO_BASE 12'h008
`define VPI_OFS_TRAPCTL 12'h018
`define VPI_OFS_EXTCTL 12'h01C
`define VPI_OFS_DMALOOP 12'h020
`define VPI_OFS_SOFTHARD 12'h024
`define VPI_OFS_PENDING 12'h028
`define VPI_OFS_CPUSTAT 12'h02C
`define VPI_OFS_CORECTL 12'h030

`define VPI_BIT_NESTDIS 15
`define VPI_BIT_OSC 1
`define VPI_BIT_STACK 2
`define VPI_BIT_ADDR 3
`define VPI_BIT_MATH 4
`define VPI_BIT_DMA_CONTROLLER 5
`define VPI_BIT_GIE 15
`define VPI_BIT_DMAADDR 5
`define VPI_BIT_LOOPOVF 4
`define VPI_BIT_SWHARD 0
`define VPI_BIT_CPU_LO 5
`define VPI_BIT_CPU_TOP 3
`define VPI_BIT_LEVEL 8

`define VPI_RST_EXTCTL 32'h0000_8000
`define VPI_RST_WORD 32'h0000_0000

`endif

// *** vpi_sync.sv ***
// Two-flop synchroniser for a bus of independent levels.
// Assumes each bit is a slow level from a pin or another clock.
`default_nettype none
module vpi_sync #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic REF_CLK_I,
  input wire logic RESET_I,
  // Levels
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge REF_CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      meta <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta <= async_i;
      sync_o <= meta;
    end
  end
endmodule // vpi_sync
`default_nettype wire

// *** vpi_tb.sv ***
// Self-checking bench for the vectored interrupt controller.
// Assumes vpi_ctrl and vpi_core_model are compiled before it.
`include "vpi_regs.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import vpi_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic ack_en = 1'b0;
  logic ret = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [15:0] src = 16'h0000;
  logic [7:0] trap = 8'h00;
  logic pready, pslverr, irq, ack, err;
  logic [31:0] prdata, rd;
  vpi_vec_t vec;
  vpi_level_t lvl, cpul;
  int fails = 0;
  int total_checks = 0;
  always #10 clk = ~clk;
  vpi_ctrl vpi_ctrl_inst (.REF_CLK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .PRDATA_O(prdata),
    .SRC_REQ_I(src), .TRAP_I(trap), .ACK_I(ack), .RETURN_I(ret), .IRQ_O(irq), .VECTOR_O(vec),
    .LEVEL_O(lvl), .CPU_LEVEL_O(cpul));
  vpi_core_model #(.LAT(2)) vpi_core_model_inst (.clk_i(clk), .rst_i(rst), .irq_i(irq), .en_i(ack_en),
    .ack_o(ack));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // Sync, flag and output stages have all landed
  task automatic settle();
    repeat (6) @(negedge clk);
  endtask
  task automatic pending(input logic i, input logic [7:0] v, input logic [3:0] l);
    check({31'h0, irq}, {31'h0, i});
    check({24'h0, vec}, {24'h0, v});
    check({28'h0, lvl}, {28'h0, l});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [11:0] a [10];
    a = '{`VPI_OFS_FLAG, `VPI_OFS_ENABLE, `VPI_OFS_PRIO_BASE, `VPI_OFS_TRAPCTL, `VPI_OFS_EXTCTL,
      `VPI_OFS_DMALOOP, `VPI_OFS_SOFTHARD, `VPI_OFS_PENDING, `VPI_OFS_CPUSTAT, `VPI_OFS_CORECTL};
    pending(1'b0, 8'h00, 4'h0);
    foreach (a[i])
    begin
      apb(1'b0, a[i], 32'h0);
      check(rd, a[i] == `VPI_OFS_EXTCTL ? `VPI_RST_EXTCTL : `VPI_RST_WORD);
      check({31'h0, err}, 32'h0);
    end
  endtask
  task automatic t_unmapped();
    apb(1'b1, 12'h034, 32'hFFFF_FFFF);
    check({31'h0, err}, 32'h1);
    apb(1'b0, 12'h034, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, `VPI_OFS_PENDING, 32'hFFFF_FFFF);
    apb(1'b0, `VPI_OFS_PENDING, 32'h0);
    check(rd, 32'h0);
  endtask
  task automatic t_traps();
    logic [7:0] v [8];
    logic [11:0] a [8];
    int b [8];
    v = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h05, 8'h06, 8'h06, 8'h02};
    a = '{`VPI_OFS_TRAPCTL, `VPI_OFS_TRAPCTL, `VPI_OFS_TRAPCTL, `VPI_OFS_TRAPCTL, `VPI_OFS_TRAPCTL,
      `VPI_OFS_DMALOOP, `VPI_OFS_DMALOOP, `VPI_OFS_SOFTHARD};
    b = '{`VPI_BIT_OSC, `VPI_BIT_ADDR, `VPI_BIT_STACK, `VPI_BIT_MATH, `VPI_BIT_DMA_CONTROLLER, `VPI_BIT_DMAADDR,
      `VPI_BIT_LOOPOVF, `VPI_BIT_SWHARD};
    // Traps must pass with global enable off and the core at its top low level
    apb(1'b1, `VPI_OFS_EXTCTL, 32'h0);
    apb(1'b1, `VPI_OFS_CPUSTAT, 32'hE0);
    foreach (v[i])
    begin
      @(posedge clk);
      trap <= 8'h01 << i;
      @(posedge clk);
      trap <= 8'h00;
      settle();
      pending(1'b1, v[i], 4'hF - v[i][3:0]);
      apb(1'b0, `VPI_OFS_PENDING, 32'h0);
      check(rd, {20'h0, 4'hF - v[i][3:0], v[i]});
      apb(1'b0, a[i], 32'h0);
      check(rd, 32'h1 << b[i]);
      if (i == 0)
      begin
        ack_en <= 1'b1;
        settle();
        @(posedge clk);
        ack_en <= 1'b0;
        check({28'h0, cpul}, 32'hF);
        apb(1'b1, `VPI_OFS_CORECTL, 32'h0);
        apb(1'b0, `VPI_OFS_CORECTL, 32'h0);
        check(rd, 32'h8);
        @(posedge clk);
        ret <= 1'b1;
        @(posedge clk);
        ret <= 1'b0;
        settle();
        check({28'h0, cpul}, 32'h7);
      end
      apb(1'b1, a[i], 32'h1 << b[i]);
      settle();
      check({31'h0, irq}, 32'h0);
    end
    apb(1'b1, `VPI_OFS_EXTCTL, `VPI_RST_EXTCTL);
    apb(1'b1, `VPI_OFS_CPUSTAT, 32'h0);
  endtask
  task automatic t_prio();
    apb(1'b1, `VPI_OFS_ENABLE, 32'h18);
    apb(1'b1, `VPI_OFS_PRIO_BASE, 32'h5000);
    apb(1'b1, `VPI_OFS_PRIO_BASE + 12'h004, 32'h5);
    @(posedge clk);
    src <= 16'h0018;
    settle();
    pending(1'b1, 8'h0B, 4'h5);
    apb(1'b1, `VPI_OFS_PRIO_BASE + 12'h004, 32'h6);
    settle();
    pending(1'b1, 8'h0C, 4'h6);
    apb(1'b1, `VPI_OFS_CPUSTAT, 32'hC0);
    settle();
    check({31'h0, irq}, 32'h0);
    apb(1'b1, `VPI_OFS_CPUSTAT, 32'hA0);
    settle();
    pending(1'b1, 8'h0C, 4'h6);
    apb(1'b1, `VPI_OFS_EXTCTL, 32'h0);
    settle();
    check({31'h0, irq}, 32'h0);
    apb(1'b1, `VPI_OFS_EXTCTL, `VPI_RST_EXTCTL);
    ack_en <= 1'b1;
    settle();
    @(posedge clk);
    ack_en <= 1'b0;
    check({28'h0, cpul}, 32'h6);
    apb(1'b0, `VPI_OFS_CPUSTAT, 32'h0);
    check(rd, 32'hC0);
    apb(1'b1, `VPI_OFS_CPUSTAT, 32'h0);
    apb(1'b1, `VPI_OFS_ENABLE, 32'h08);
    settle();
    pending(1'b1, 8'h0B, 4'h5);
    @(posedge clk);
    src <= 16'h0000;
    settle();
    apb(1'b0, `VPI_OFS_FLAG, 32'h0);
    check(rd, 32'h18);
    apb(1'b1, `VPI_OFS_FLAG, 32'h18);
    apb(1'b0, `VPI_OFS_FLAG, 32'h0);
    check(rd, 32'h0);
  endtask
  task automatic t_edge();
    apb(1'b1, `VPI_OFS_ENABLE, 32'h1);
    apb(1'b1, `VPI_OFS_PRIO_BASE, 32'h3);
    apb(1'b1, `VPI_OFS_EXTCTL, 32'h8001);
    @(posedge clk);
    src <= 16'h0001;
    settle();
    check({31'h0, irq}, 32'h0);
    @(posedge clk);
    src <= 16'h0000;
    settle();
    pending(1'b1, 8'h08, 4'h3);
    apb(1'b1, `VPI_OFS_FLAG, 32'h1);
    apb(1'b1, `VPI_OFS_EXTCTL, `VPI_RST_EXTCTL);
    settle();
    check({31'h0, irq}, 32'h0);
    @(posedge clk);
    src <= 16'h0001;
    @(posedge clk);
    src <= 16'h0000;
    settle();
    pending(1'b1, 8'h08, 4'h3);
    // Nesting disabled: accepted user handler runs at low level 7
    apb(1'b1, `VPI_OFS_TRAPCTL, 32'h8000);
    ack_en <= 1'b1;
    settle();
    @(posedge clk);
    ack_en <= 1'b0;
    check({28'h0, cpul}, 32'h7);
    check({31'h0, irq}, 32'h0);
    apb(1'b0, `VPI_OFS_TRAPCTL, 32'h0);
    check(rd, 32'h8000);
    apb(1'b1, `VPI_OFS_TRAPCTL, 32'h0);
    apb(1'b1, `VPI_OFS_CPUSTAT, 32'h0);
    apb(1'b1, `VPI_OFS_FLAG, 32'h1);
    apb(1'b1, `VPI_OFS_ENABLE, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_unmapped();
    t_traps();
    t_prio();
    t_edge();
    stop_test();
  end
  // Whole run needs well under a tenth of this
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    stop_test();
  end
endmodule // testbench
`default_nettype wire
